// file: core/rf_framing_consts.svh
// Constants for the framing configuration register bank
// How it works
// - Subcarrier code 01 gives carrier/32, 00 carrier/16 BPSK, others reserved.
// - Pulse code 10 gives 4, 11 gives 8 pulses per report; others reserved.
// - Modulator period 000..011 gives carrier/128,/64,/32,/16; top bit set reserved.
// - Auxiliary bit 7 clear checks received CRC; set skips the check.
// - Short request, wake-up or anticollision always receive without CRC check.
// - Phase-clock bit picks 0 or 90 degree shifted measurement clock.
// - Correlation-disable 0 selects correlation reception; 1 is reserved.
// - Two-bit count gives n used by the two field-on commands.
// - EMD bit 7 set enables collision-noise frame suppression, clear disables.
// - Type A 106k receive start needs error-free first 4 bits unless bit set.
// - With EMD bit 7 set, erroneous frame shorter than byte threshold is suppressed, not reported.
// - Early type B subcarrier with suppression on suppresses frame, raises restart.
`ifndef RF_FRAMING_CONSTS_SVH
`define RF_FRAMING_CONSTS_SVH

// ---------------------------------------------
// Register indices, byte address is index times four
// ---------------------------------------------
`define IDX_EMD 8'h05
`define IDX_STREAM 8'h09
`define IDX_AUX 8'h0a
`define IDX_IRQ_STAT 8'h10
`define IDX_IRQ_MASK 8'h11
`define IDX_LSB 2
`define IDX_MSB 9
`define ADDR_HI_LSB 10

// ---------------------------------------------
// Writable bit masks and reset values
// ---------------------------------------------
`define MASK_STREAM 8'h7f
`define MASK_AUX 8'hbf
`define MASK_EMD 8'hcf
`define MASK_IRQ 8'h1f
`define RST_REG 8'h00

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define SCF_MSB 6
`define SCF_LSB 5
`define SCP_MSB 4
`define SCP_LSB 3
`define STX_MSB 2
`define STX_LSB 0
`define AUX_NO_CRC 7
`define AUX_ID_MSB 5
`define AUX_ID_LSB 4
`define AUX_PHASE90 3
`define AUX_DIS_CORR 2
`define AUX_N_MSB 1
`define AUX_N_LSB 0
`define EMD_EN 7
`define EMD_RXS 6
`define EMD_THLD_MSB 3
`define EMD_THLD_LSB 0

// ---------------------------------------------
// Interrupt status bits
// ---------------------------------------------
`define IRQ_RX_START 0
`define IRQ_SUPPRESS 1
`define IRQ_RESTART 2
`define IRQ_SOFT_ERR 3
`define IRQ_CFG_ERR 4

// ---------------------------------------------
// Field codes and carrier division ratios
// ---------------------------------------------
`define SCF_BPSK 2'b00
`define SCF_SUB 2'b01
`define SCP_4 2'b10
`define SCP_8 2'b11
`define ID_4B 2'b00
`define ID_7B 2'b01
`define DIV_128 8'h80
`define DIV_64 8'h40
`define DIV_32 8'h20
`define DIV_16 8'h10
`define DIV_NONE 8'h00
`define PULSES_4 4'h4
`define PULSES_8 4'h8
`define PULSES_NONE 4'h0

`endif

// file: core/rf_framing_pkg.sv
// Types shared by the framing configuration register bank
package rf_framing_pkg;

  // ---------------------------------------------
  // Bus address phase held for the data phase
  // ---------------------------------------------
  typedef struct packed {
    logic pend;
    logic write;
    logic [7:0] idx;
  } bus_req_s;

  // ---------------------------------------------
  // Decoded settings handed to the framing engine
  // ---------------------------------------------
  typedef struct packed {
    logic [7:0] sc_div;
    logic [3:0] pulses;
    logic [7:0] tx_div;
    logic crc_check;
    logic id_7byte;
    logic phase90;
    logic corr_rx;
    logic emd_en;
  } frame_cfg_s;

endpackage : rf_framing_pkg

// file: core/rf_framing_config_regs.sv
// Framing configuration register bank with AHB-Lite slave and interrupts
//
// The AHB-Lite slave port was decided locally.
`include "rf_framing_consts.svh"

module rf_framing_config_regs #(
  parameter int DIV_W = 8
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic CMD_SHORT_REQ,
  input wire logic CMD_WAKEUP,
  input wire logic CMD_FIELD_ON,
  input wire logic ANTICOLL_ACTIVE,
  input wire logic TYPEA_106,
  input wire logic FIRST4_DONE,
  input wire logic FIRST4_ERR,
  input wire logic RX_FRAME_END,
  input wire logic RX_ERROR,
  input wire logic [3:0] RX_BYTES,
  input wire logic TYPEB_SC_EARLY,
  output logic [DIV_W-1:0] SC_DIV,
  output logic [3:0] PULSES_PER_REPORT,
  output logic [DIV_W-1:0] TX_MOD_DIV,
  output logic CRC_CHECK_EN,
  output logic ID_SIZE_7B,
  output logic PHASE_CLK_90,
  output logic CORR_RX,
  output logic EMD_ENABLE,
  output logic [1:0] FIELD_ON_N,
  output logic RX_START,
  output logic FRAME_REPORT,
  output logic FRAME_SUPPRESS,
  output logic IRQ
);

  // ---------------------------------------------
  // Elaboration check
  // ---------------------------------------------
  // Ratios reach 128, so narrower dividers cannot be served
  if (DIV_W < 8)
  begin : g_bad_width
    $error("DIV_W must be at least 8");
  end

  // ---------------------------------------------
  // Storage
  // ---------------------------------------------
  logic [7:0] stream_q;
  logic [7:0] stream_d;
  logic [7:0] aux_q;
  logic [7:0] aux_d;
  logic [7:0] emd_q;
  logic [7:0] emd_d;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] hw_set;
  logic [7:0] wr_val;
  rf_framing_pkg::bus_req_s req_q;
  rf_framing_pkg::frame_cfg_s cfg;
  logic addr_ok;
  logic [7:0] addr_idx;
  logic take;
  logic wr_now;
  logic nocrc_auto_q;
  logic cfg_bad;
  logic suppress_now;
  logic rx_start_now;

  // ---------------------------------------------
  // AHB-Lite address phase
  // ---------------------------------------------
  // Only whole words are mapped; upper address bits must be zero
  assign addr_idx = HADDR[`IDX_MSB:`IDX_LSB];
  assign addr_ok = (HADDR[31:`ADDR_HI_LSB] == 22'h000000) && (HADDR[1:0] == 2'b00);
  assign take = HSEL && HTRANS[1] && HREADY;
  assign wr_now = req_q.pend && req_q.write;
  assign wr_val = HWDATA[7:0];

  // Address phase latch; zero wait states so the slave is always ready
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      req_q <= '0;
    end
    else
    begin
      req_q.pend <= take;
      req_q.write <= take && HWRITE;
      req_q.idx <= addr_ok ? addr_idx : 8'hff;
    end
  end

  // Ready and response never change: no waits and always OKAY
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Next register values
  // ---------------------------------------------
  // Reserved bits are masked off on write so they read zero
  always_comb
  begin
    stream_d = stream_q;
    aux_d = aux_q;
    emd_d = emd_q;
    mask_d = mask_q;
    if (wr_now && req_q.idx == `IDX_STREAM)
    begin
      stream_d = wr_val & `MASK_STREAM;
    end
    if (wr_now && req_q.idx == `IDX_AUX)
    begin
      aux_d = wr_val & `MASK_AUX;
    end
    if (wr_now && req_q.idx == `IDX_EMD)
    begin
      emd_d = wr_val & `MASK_EMD;
    end
    if (wr_now && req_q.idx == `IDX_IRQ_MASK)
    begin
      mask_d = wr_val & `MASK_IRQ;
    end
  end

  // Write-one clears, but a hardware event in the same cycle wins
  always_comb
  begin
    stat_d = stat_q;
    if (wr_now && req_q.idx == `IDX_IRQ_STAT)
    begin
      stat_d = stat_q & ~wr_val;
    end
    stat_d = (stat_d | hw_set) & `MASK_IRQ;
  end

  // Configuration registers, all fields reset to zero
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      stream_q <= `RST_REG;
      aux_q <= `RST_REG;
      emd_q <= `RST_REG;
    end
    else
    begin
      stream_q <= stream_d;
      aux_q <= aux_d;
      emd_q <= emd_d;
    end
  end

  // Interrupt status and mask
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      stat_q <= `RST_REG;
      mask_q <= `RST_REG;
    end
    else
    begin
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // ---------------------------------------------
  // Read data
  // ---------------------------------------------
  // Read from next values so a write just before is seen at once
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      HRDATA <= 32'h00000000;
    end
    else if (take && !HWRITE)
    begin
      case (addr_ok ? addr_idx : 8'hff)
        `IDX_STREAM: HRDATA <= {24'h000000, stream_d};
        `IDX_AUX: HRDATA <= {24'h000000, aux_d};
        `IDX_EMD: HRDATA <= {24'h000000, emd_d};
        `IDX_IRQ_STAT: HRDATA <= {24'h000000, stat_d};
        `IDX_IRQ_MASK: HRDATA <= {24'h000000, mask_d};
        default: HRDATA <= 32'h00000000; // Unmapped reads zero
      endcase
    end
  end

  // ---------------------------------------------
  // Field decode
  // ---------------------------------------------
  always_comb
  begin
    cfg = '0;
    cfg_bad = 1'b0;
    // Subcarrier frequency
    case (stream_q[`SCF_MSB:`SCF_LSB])
      `SCF_SUB: cfg.sc_div = `DIV_32;
      `SCF_BPSK: cfg.sc_div = `DIV_16;
      default:
      begin
        cfg.sc_div = `DIV_NONE;
        cfg_bad = 1'b1;
      end
    endcase
    // Pulses per report period; reset code is reserved too
    case (stream_q[`SCP_MSB:`SCP_LSB])
      `SCP_4: cfg.pulses = `PULSES_4;
      `SCP_8: cfg.pulses = `PULSES_8;
      default: cfg.pulses = `PULSES_NONE;
    endcase
    // Modulator period; top bit set is reserved
    case (stream_q[`STX_MSB:`STX_LSB])
      3'b000: cfg.tx_div = `DIV_128;
      3'b001: cfg.tx_div = `DIV_64;
      3'b010: cfg.tx_div = `DIV_32;
      3'b011: cfg.tx_div = `DIV_16;
      default:
      begin
        cfg.tx_div = `DIV_NONE;
        cfg_bad = 1'b1;
      end
    endcase
    // Automatic no-CRC cases override the software bit
    cfg.crc_check = !(aux_q[`AUX_NO_CRC] || nocrc_auto_q || ANTICOLL_ACTIVE);
    cfg.id_7byte = (aux_q[`AUX_ID_MSB:`AUX_ID_LSB] == `ID_7B);
    if (aux_q[`AUX_ID_MSB])
    begin
      cfg_bad = 1'b1;
    end
    cfg.phase90 = aux_q[`AUX_PHASE90];
    cfg.corr_rx = !aux_q[`AUX_DIS_CORR];
    if (aux_q[`AUX_DIS_CORR])
    begin
      cfg_bad = 1'b1;
    end
    cfg.emd_en = emd_q[`EMD_EN];
  end

  // Registered settings, so every output comes from a flip-flop
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      SC_DIV <= '0;
      PULSES_PER_REPORT <= `PULSES_NONE;
      TX_MOD_DIV <= '0;
      CRC_CHECK_EN <= 1'b0;
      ID_SIZE_7B <= 1'b0;
      PHASE_CLK_90 <= 1'b0;
      CORR_RX <= 1'b0;
      EMD_ENABLE <= 1'b0;
    end
    else
    begin
      SC_DIV <= DIV_W'(cfg.sc_div);
      PULSES_PER_REPORT <= cfg.pulses;
      TX_MOD_DIV <= DIV_W'(cfg.tx_div);
      CRC_CHECK_EN <= cfg.crc_check;
      ID_SIZE_7B <= cfg.id_7byte;
      PHASE_CLK_90 <= cfg.phase90;
      CORR_RX <= cfg.corr_rx;
      EMD_ENABLE <= cfg.emd_en;
    end
  end

  // ---------------------------------------------
  // Automatic no-CRC window
  // ---------------------------------------------
  // Opens at a short request or wake-up, closes at the answer's end
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      nocrc_auto_q <= 1'b0;
    end
    else if (CMD_SHORT_REQ || CMD_WAKEUP)
    begin
      nocrc_auto_q <= 1'b1;
    end
    else if (RX_FRAME_END)
    begin
      nocrc_auto_q <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Field-on count capture
  // ---------------------------------------------
  // Latched at the command, so later writes do not disturb a running one
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      FIELD_ON_N <= 2'b00;
    end
    else if (CMD_FIELD_ON)
    begin
      FIELD_ON_N <= aux_q[`AUX_N_MSB:`AUX_N_LSB];
    end
  end

  // ---------------------------------------------
  // Receive start and frame disposition
  // ---------------------------------------------
  // Errors in the first nibble block the start only for type A 106k
  assign rx_start_now = FIRST4_DONE && (!TYPEA_106 || !FIRST4_ERR || emd_q[`EMD_RXS]);
  // Short erroneous frames are noise once suppression is on
  assign suppress_now = RX_FRAME_END && emd_q[`EMD_EN] && RX_ERROR
    && (RX_BYTES < emd_q[`EMD_THLD_MSB:`EMD_THLD_LSB]);

  // One-cycle strobes to the framing engine
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      RX_START <= 1'b0;
      FRAME_REPORT <= 1'b0;
      FRAME_SUPPRESS <= 1'b0;
    end
    else
    begin
      RX_START <= rx_start_now;
      FRAME_REPORT <= RX_FRAME_END && !suppress_now;
      FRAME_SUPPRESS <= suppress_now || (TYPEB_SC_EARLY && emd_q[`EMD_EN]);
    end
  end

  // ---------------------------------------------
  // Interrupt events
  // ---------------------------------------------
  // Early subcarrier is a restart with suppression on, else a soft error
  always_comb
  begin
    hw_set = 8'h00;
    hw_set[`IRQ_RX_START] = rx_start_now;
    hw_set[`IRQ_SUPPRESS] = suppress_now || (TYPEB_SC_EARLY && emd_q[`EMD_EN]);
    hw_set[`IRQ_RESTART] = TYPEB_SC_EARLY && emd_q[`EMD_EN];
    hw_set[`IRQ_SOFT_ERR] = TYPEB_SC_EARLY && !emd_q[`EMD_EN];
    hw_set[`IRQ_CFG_ERR] = cfg_bad;
  end

  // Level interrupt while any unmasked status bit stands
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(stat_d & mask_d);
    end
  end

endmodule : rf_framing_config_regs

// file: tb/rf_peer_model.sv
// Behavioural RF peer presenting framing events to the bank
module rf_peer_model (
  input wire logic clk,
  input wire logic [2:0] kind,
  input wire logic err,
  input wire logic [3:0] nbytes,
  output logic first4_done = 1'b0,
  output logic first4_err = 1'b0,
  output logic frame_end = 1'b0,
  output logic rx_err = 1'b0,
  output logic [3:0] rx_bytes = 4'h0,
  output logic sc_early = 1'b0
);
  // ----------------------------------------
  // Event pulses
  // ----------------------------------------
  // Qualifiers flip while idle so nobody may trust stale values
  always @(posedge clk)
  begin
    first4_done <= kind[0];
    frame_end <= kind[1];
    sc_early <= kind[2];
    first4_err <= (kind != 3'h0) ? err : ~first4_err;
    rx_err <= (kind != 3'h0) ? err : ~rx_err;
    rx_bytes <= (kind != 3'h0) ? nbytes : ~rx_bytes;
  end
endmodule : rf_peer_model

// file: tb/rf_cfg_properties.sv
// Port checker for the framing configuration bank
module rf_cfg_checker #(
  parameter int DIV_W = 8
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HREADYOUT,
  input wire logic [31:0] HRDATA,
  input wire logic HRESP,
  input wire logic CMD_SHORT_REQ,
  input wire logic CMD_WAKEUP,
  input wire logic CMD_FIELD_ON,
  input wire logic ANTICOLL_ACTIVE,
  input wire logic TYPEA_106,
  input wire logic FIRST4_DONE,
  input wire logic FIRST4_ERR,
  input wire logic RX_FRAME_END,
  input wire logic TYPEB_SC_EARLY,
  input wire logic [DIV_W-1:0] SC_DIV,
  input wire logic [DIV_W-1:0] TX_MOD_DIV,
  input wire logic CRC_CHECK_EN,
  input wire logic EMD_ENABLE,
  input wire logic [1:0] FIELD_ON_N,
  input wire logic RX_START,
  input wire logic FRAME_REPORT,
  input wire logic FRAME_SUPPRESS
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  // ----------------------------------------
  // Bus and decoded settings
  // ----------------------------------------
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not zero-wait okay");
  a_rd_upper_zero: assert property (HRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_sc_legal: assert property (SC_DIV inside {0, 16, 32})
    else $error("subcarrier divider illegal");
  a_tx_legal: assert property (TX_MOD_DIV inside {0, 16, 32, 64, 128})
    else $error("modulator divider illegal");
  // Auto skip lags the command by two edges through the flag
  a_crc_auto: assert property ((CMD_SHORT_REQ || CMD_WAKEUP) |-> ##2 !CRC_CHECK_EN)
    else $error("crc check kept after short command");
  a_anticoll_crc: assert property (ANTICOLL_ACTIVE |=> !CRC_CHECK_EN)
    else $error("crc check kept in anticollision");
  a_field_n_hold: assert property (!CMD_FIELD_ON |=> $stable(FIELD_ON_N))
    else $error("field-on count moved without command");

  // ----------------------------------------
  // Framing strobes
  // ----------------------------------------
  a_rxs_cause: assert property (!FIRST4_DONE |=> !RX_START)
    else $error("receive start without cause");
  a_rxs_clean: assert property (FIRST4_DONE && (!TYPEA_106 || !FIRST4_ERR) |=> RX_START)
    else $error("receive start missing");
  a_frame_once: assert property (RX_FRAME_END |=> FRAME_REPORT != FRAME_SUPPRESS)
    else $error("frame not reported exactly once");
  a_early_sup: assert property (EMD_ENABLE && TYPEB_SC_EARLY |=> FRAME_SUPPRESS)
    else $error("early subcarrier not suppressed");

  c_suppress: cover property (FRAME_SUPPRESS);
  c_rx_start: cover property (RX_START);
  c_field_n: cover property (FIELD_ON_N == 2'b11);
endmodule : rf_cfg_checker

bind rf_framing_config_regs rf_cfg_checker #(.DIV_W(DIV_W)) u_chk (.CLK, .NRST, .HREADYOUT, .HRDATA,
  .HRESP, .CMD_SHORT_REQ, .CMD_WAKEUP, .CMD_FIELD_ON, .ANTICOLL_ACTIVE, .TYPEA_106, .FIRST4_DONE,
  .FIRST4_ERR, .RX_FRAME_END, .TYPEB_SC_EARLY, .SC_DIV, .TX_MOD_DIV, .CRC_CHECK_EN, .EMD_ENABLE,
  .FIELD_ON_N, .RX_START, .FRAME_REPORT, .FRAME_SUPPRESS);

// file: tb/tb.sv
// Self-checking bench for the framing configuration bank
`include "rf_framing_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'b00;
  logic [2:0] HSIZE = 3'b010;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic CMD_SHORT_REQ = 1'b0, CMD_WAKEUP = 1'b0, CMD_FIELD_ON = 1'b0, ANTICOLL_ACTIVE = 1'b0, TYPEA_106 = 1'b0;
  logic [2:0] kind = 3'b000;
  logic err = 1'b0, rd_ph = 1'b0, ev_ph = 1'b0;
  logic [3:0] nbytes = 4'h0;
  logic HREADYOUT, HRESP, CRC_CHECK_EN, ID_SIZE_7B, PHASE_CLK_90, CORR_RX, EMD_ENABLE, IRQ;
  logic RX_START, FRAME_REPORT, FRAME_SUPPRESS, FIRST4_DONE, FIRST4_ERR, RX_FRAME_END, RX_ERROR, TYPEB_SC_EARLY;
  logic [31:0] HRDATA;
  logic [7:0] SC_DIV, TX_MOD_DIV;
  logic [3:0] PULSES_PER_REPORT, RX_BYTES;
  logic [1:0] FIELD_ON_N;
  logic [31:0] q[$];
  logic [31:0] d, r, got, exp_v;
  integer seed = 32'h0d7a;
  int failures = 0;
  int checks_done = 0;

  rf_framing_config_regs #(.DIV_W(8)) dut (.CLK, .NRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HREADYOUT, .HRDATA, .HRESP, .CMD_SHORT_REQ, .CMD_WAKEUP, .CMD_FIELD_ON,
    .ANTICOLL_ACTIVE, .TYPEA_106, .FIRST4_DONE, .FIRST4_ERR, .RX_FRAME_END, .RX_ERROR, .RX_BYTES,
    .TYPEB_SC_EARLY, .SC_DIV, .PULSES_PER_REPORT, .TX_MOD_DIV, .CRC_CHECK_EN, .ID_SIZE_7B, .PHASE_CLK_90,
    .CORR_RX, .EMD_ENABLE, .FIELD_ON_N, .RX_START, .FRAME_REPORT, .FRAME_SUPPRESS, .IRQ);

  rf_peer_model peer (.clk(CLK), .kind(kind), .err(err), .nbytes(nbytes), .first4_done(FIRST4_DONE),
    .first4_err(FIRST4_ERR), .frame_end(RX_FRAME_END), .rx_err(RX_ERROR), .rx_bytes(RX_BYTES),
    .sc_early(TYPEB_SC_EARLY));

  // ----------------------------------------
  // Clock, tasks and result monitor
  // ----------------------------------------
  // 100 MHz clock
  always #5 CLK = ~CLK;

  task automatic results;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // Bounded wait; a hang counts as a mismatch
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (HREADYOUT !== 1'b1 && n < 16);
    // Ready seen on the last allowed edge is still a good answer
    if (HREADYOUT !== 1'b1)
    begin
      failures++;
      results();
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [31:0] ex);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {22'h0, idx, 2'b00};
    HWRITE <= wr;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    rd_ph <= !wr;
    if (!wr)
      q.push_back(ex);
    wait_rdy();
    rd_ph <= 1'b0;
  endtask : bus

  // One peer event; x is the expected {start, report, suppress}
  task automatic ev(input logic [2:0] k, input logic e, input logic [3:0] b, input logic [2:0] x);
    @(posedge CLK);
    kind <= k;
    err <= e;
    nbytes <= b;
    @(posedge CLK);
    kind <= 3'b000;
    @(posedge CLK);
    ev_ph <= 1'b1;
    q.push_back({29'h0, x});
    @(posedge CLK);
    ev_ph <= 1'b0;
  endtask : ev

  // Oldest note is compared whenever a read or strobe is due
  always @(posedge CLK)
  begin
    if (rd_ph || ev_ph)
    begin
      exp_v = q.pop_front();
      got = rd_ph ? HRDATA : {29'h0, RX_START, FRAME_REPORT, FRAME_SUPPRESS};
      `CHK(got, exp_v)
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    bus(0, `IDX_STREAM, 0, 0);
    bus(0, `IDX_EMD, 0, 0);
    #1;
    `CHK(TX_MOD_DIV, 8'd128)
    `CHK(CORR_RX, 1'b1)
    `CHK(ID_SIZE_7B, 1'b0)
    $display("done reset");
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      d = {24'h0, r[7], i[1:0], i[2:1], i[2:0]};
      bus(1, `IDX_STREAM, d, 0);
      bus(0, `IDX_STREAM, 0, d & 32'h7f);
      #1;
      `CHK(SC_DIV, (d[6:5] == 2'b01) ? 8'd32 : (d[6:5] == 2'b00) ? 8'd16 : 8'd0)
      `CHK(PULSES_PER_REPORT, d[4] ? (d[3] ? 4'd8 : 4'd4) : 4'd0)
      `CHK(TX_MOD_DIV, d[2] ? 8'd0 : 8'd128 >> d[1:0])
    end
    bus(1, `IDX_STREAM, 0, 0);
    $display("done stream");
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      d = {24'h0, i[0], r[6], i[1:0], i[0], i[1], i[1:0]};
      bus(1, `IDX_AUX, d, 0);
      bus(0, `IDX_AUX, 0, d & 32'hbf);
      @(posedge CLK);
      CMD_FIELD_ON <= 1'b1;
      @(posedge CLK);
      CMD_FIELD_ON <= 1'b0;
      repeat (2) @(posedge CLK);
      #1;
      `CHK(CRC_CHECK_EN, !d[7])
      `CHK(PHASE_CLK_90, d[3])
      `CHK(CORR_RX, !d[2])
      `CHK(FIELD_ON_N, d[1:0])
      `CHK(ID_SIZE_7B, d[5:4] == 2'b01)
    end
    // Count is latched at the command, so a later write must not show
    bus(1, `IDX_AUX, 0, 0);
    repeat (2) @(posedge CLK);
    #1;
    `CHK(FIELD_ON_N, 2'b11)
    for (int i = 0; i < 3; i++)
    begin
      @(posedge CLK);
      CMD_SHORT_REQ <= (i == 0);
      CMD_WAKEUP <= (i == 1);
      ANTICOLL_ACTIVE <= (i == 2);
      @(posedge CLK);
      CMD_SHORT_REQ <= 1'b0;
      CMD_WAKEUP <= 1'b0;
      repeat (2) @(posedge CLK);
      #1;
      `CHK(CRC_CHECK_EN, 1'b0)
      @(posedge CLK);
      ANTICOLL_ACTIVE <= 1'b0;
      ev(3'b010, 1'b0, 4'h1, 3'b010);
      repeat (2) @(posedge CLK);
      #1;
      `CHK(CRC_CHECK_EN, 1'b1)
    end
    $display("done aux");
    @(posedge CLK);
    TYPEA_106 <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      bus(1, `IDX_EMD, {24'h0, 1'b0, i[1], 6'h0}, 0);
      ev(3'b001, i[0], 4'h0, {!(i[0] && !i[1]), 2'b00});
    end
    // Tolerance bit off, so only the protocol can excuse the bad nibble
    bus(1, `IDX_EMD, 0, 0);
    @(posedge CLK);
    TYPEA_106 <= 1'b0;
    ev(3'b001, 1'b1, 4'h0, 3'b100);
    $display("done rx start");
    bus(1, `IDX_EMD, 32'hc4, 0);
    repeat (2) @(posedge CLK);
    #1;
    `CHK(EMD_ENABLE, 1'b1)
    ev(3'b010, 1'b1, 4'h3, 3'b001);
    ev(3'b010, 1'b1, 4'h4, 3'b010);
    ev(3'b010, 1'b0, 4'h1, 3'b010);
    bus(1, `IDX_IRQ_STAT, 32'h1f, 0);
    bus(1, `IDX_IRQ_MASK, 32'h04, 0);
    ev(3'b100, 1'b0, 4'h0, 3'b001);
    #1;
    `CHK(IRQ, 1'b1)
    bus(0, `IDX_IRQ_STAT, 0, 32'h06);
    bus(1, `IDX_IRQ_STAT, 32'h04, 0);
    repeat (2) @(posedge CLK);
    #1;
    `CHK(IRQ, 1'b0)
    bus(1, `IDX_EMD, 0, 0);
    ev(3'b010, 1'b1, 4'h1, 3'b010);
    // Early subcarrier with suppression off is only a soft error
    ev(3'b100, 1'b0, 4'h0, 3'b000);
    bus(0, `IDX_IRQ_STAT, 0, 32'h0a);
    $display("done suppression");
    bus(1, 8'h07, 32'hff, 0);
    bus(0, 8'h07, 0, 0);
    bus(1, `IDX_EMD, 32'hff, 0);
    bus(0, `IDX_EMD, 0, 32'hcf);
    $display("done map");
    results();
  end
endmodule : tb
